// ### rtl/t1_block_framer_map.vh
// constants for the card-side block framer: field codes, defaults, states
// assumes one byte per transfer on the line and one byte per apdu word
//
// Function
// - card answers only node address zero, sends zero address byte
// - i-block with nonzero address is dropped with no answer
// - control byte alone carries control and tells the block type
// - i-, r- and s-blocks are all parsed and built
// - length byte equals the count of information bytes
// - information length ranges 0 to 254, by block type
// - i-block always carries information bytes
// - r-block carries no information bytes
// - size and wait-extension s-blocks carry exactly one byte
// - abort and resync s-blocks carry no information
// - i-block with bad check byte answered by r-block, code 1
// - size request answered by size response echoing the value
// - resync request answered by empty resync response
// - abort during chained response answered by empty abort response
// - epilogue uses longitudinal redundancy check
// - epilogue is one check byte, correct for the block
// - size above 254 refused with r-block, code 2
// - terminal receive size is 32 after reset
`ifndef T1_BLOCK_FRAMER_MAP_VH
`define T1_BLOCK_FRAMER_MAP_VH

// ----------------------------------------
// prologue field codes
// ----------------------------------------
`define NAD_ZERO 8'h00
`define PCB_R_BASE 8'h80
`define PCB_S_BASE 8'hC0
`define PCB_S_RSP 8'h20
`define PCB_I_SEQ_BIT 6
`define PCB_I_MORE_BIT 5
`define PCB_R_SEQ_BIT 4
`define PCB_S_RSP_BIT 5
`define S_RESYNCH 2'h0
`define S_IFS 2'h1
`define S_ABORT 2'h2
`define S_WTX 2'h3
`define R_ERR_NONE 4'h0
`define R_ERR_EDC 4'h1
`define R_ERR_OTHER 4'h2

// ----------------------------------------
// sizes
// ----------------------------------------
`define IFSD_RESET 8'h20
`define IFSD_MAX 8'hFE
`define INF_MAX 8'hFE
`define LEN_ONE 8'h01

// ----------------------------------------
// receive states
// ----------------------------------------
`define RX_NAD 3'h0
`define RX_PCB 3'h1
`define RX_LEN 3'h2
`define RX_INF 3'h3
`define RX_LRC 3'h4
`define RX_DO 3'h5

// ----------------------------------------
// transmit states and information sources
// ----------------------------------------
`define TX_IDLE 3'h0
`define TX_NAD 3'h1
`define TX_PCB 3'h2
`define TX_LEN 3'h3
`define TX_INF 3'h4
`define TX_LRC 3'h5
`define SRC_ONE 1'b0
`define SRC_FIFO 1'b1

`endif

// ### rtl/t1_byte_fifo.v
// synchronous fifo with valid and ready on both sides
// assumes one clock; flags are registered from the next occupancy
`timescale 1ns/1ns
module t1_byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst_b,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output reg in_ready,
	output wire [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	reg [AW:0] next_count;
	wire push;
	wire pop;

	// handshakes on both sides
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// occupancy after this cycle
	always @*
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	// storage write
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and honest flags
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready <= (next_count != DEPTH[AW:0]);
			out_valid <= (next_count != {(AW+1){1'b0}});
		end
	end

endmodule // t1_byte_fifo

// ### rtl/t1_block_framer.v
// card-side block framer: parses terminal blocks, builds card blocks
// assumes byte streams in and out of a character layer; apdu side apart
`timescale 1ns/1ns
`include "t1_block_framer_map.vh"
module t1_block_framer #(
	parameter LEN_W = 16,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire clk,
	input wire rst_b,
	input wire [7:0] rx_data,
	input wire rx_valid,
	output reg rx_ready,
	output reg [7:0] tx_data,
	output reg tx_valid,
	input wire tx_ready,
	output reg [7:0] cmd_data,
	output reg cmd_valid,
	output reg cmd_done,
	output reg cmd_drop,
	input wire [7:0] rsp_data,
	input wire rsp_valid,
	output wire rsp_ready,
	input wire [LEN_W-1:0] rsp_len,
	input wire rsp_go,
	output reg rsp_wait,
	output reg rsp_chaining,
	output reg rsp_aborted,
	output reg [7:0] ifsd
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg [2:0] rx_st;
	reg [7:0] rx_nad;
	reg [7:0] rx_pcb;
	reg [7:0] rx_len;
	reg [7:0] rx_cnt;
	reg [7:0] rx_lrc;
	reg [7:0] rx_inf0;
	reg edc_ok;
	reg ns;
	reg nr;
	reg chunk_due;
	reg [LEN_W-1:0] remain;
	reg [LEN_W-1:0] flush_cnt;
	reg start_tx;
	reg [7:0] t_pcb;
	reg [7:0] t_len;
	reg [7:0] t_inf;
	reg t_src;
	reg [2:0] tx_st;
	reg [7:0] t_cnt;
	reg [7:0] t_lrc;
	wire rx_take;
	wire tx_take;
	wire tx_slot;
	wire [7:0] lrc_fold;
	wire [7:0] q_data;
	wire q_valid;
	wire q_ready;
	wire tx_pop;
	wire flushing;
	wire is_i;
	wire is_r;
	wire is_s_req;
	wire [1:0] s_type;
	wire [LEN_W-1:0] ifsd_wide;

	// ----------------------------------------
	// response buffer
	// ----------------------------------------
	t1_byte_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_rsp_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_data(rsp_data),
		.in_valid(rsp_valid),
		.in_ready(rsp_ready),
		.out_data(q_data),
		.out_valid(q_valid),
		.out_ready(q_ready)
	);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	assign rx_take = rx_valid && rx_ready;
	assign tx_take = tx_valid && tx_ready;
	assign tx_slot = !tx_valid || tx_ready;
	assign lrc_fold = t_lrc ^ (tx_take ? tx_data : 8'h00);
	assign tx_pop = (tx_st == `TX_INF) && tx_slot && (t_cnt != t_len)
		&& (t_src == `SRC_FIFO) && q_valid;
	assign flushing = (flush_cnt != {LEN_W{1'b0}});
	assign q_ready = tx_pop || flushing;
	// block type from control byte alone
	assign is_i = !rx_pcb[7];
	assign is_r = (rx_pcb[7:6] == 2'b10);
	assign is_s_req = (rx_pcb[7:6] == 2'b11) && !rx_pcb[`PCB_S_RSP_BIT];
	assign s_type = rx_pcb[1:0];
	assign ifsd_wide = {{(LEN_W-8){1'b0}}, ifsd};

	// ----------------------------------------
	// job builders
	// ----------------------------------------
	// r-block answer: empty, sequence and error code
	task send_r;
		input [3:0] code;
		input seq;
		begin
			start_tx <= 1'b1;
			t_pcb <= `PCB_R_BASE | {3'b000, seq, code};
			t_len <= 8'h00;
			t_src <= `SRC_ONE;
		end
	endtask

	// s-block response of given type
	task send_s;
		input [1:0] typ;
		input [7:0] len;
		input [7:0] inf;
		begin
			start_tx <= 1'b1;
			t_pcb <= `PCB_S_BASE | `PCB_S_RSP | {6'h00, typ};
			t_len <= len;
			t_inf <= inf;
			t_src <= `SRC_ONE;
		end
	endtask

	// ----------------------------------------
	// receive parser and block decisions
	// ----------------------------------------
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_st <= `RX_NAD;
			rx_nad <= 8'h00;
			rx_pcb <= 8'h00;
			rx_len <= 8'h00;
			rx_cnt <= 8'h00;
			rx_lrc <= 8'h00;
			rx_inf0 <= 8'h00;
			edc_ok <= 1'b0;
			rx_ready <= 1'b0;
			ns <= 1'b0;
			nr <= 1'b0;
			ifsd <= `IFSD_RESET;
			chunk_due <= 1'b0;
			remain <= {LEN_W{1'b0}};
			flush_cnt <= {LEN_W{1'b0}};
			rsp_wait <= 1'b0;
			rsp_chaining <= 1'b0;
			rsp_aborted <= 1'b0;
			start_tx <= 1'b0;
			t_pcb <= 8'h00;
			t_len <= 8'h00;
			t_inf <= 8'h00;
			t_src <= `SRC_ONE;
			cmd_data <= 8'h00;
			cmd_valid <= 1'b0;
			cmd_done <= 1'b0;
			cmd_drop <= 1'b0;
		end
		else
		begin
			start_tx <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_done <= 1'b0;
			cmd_drop <= 1'b0;
			rsp_aborted <= 1'b0;
			// half duplex: listen only while nothing is sent or pending
			rx_ready <= (tx_st == `TX_IDLE) && !start_tx && (rx_st != `RX_DO)
				&& !(rx_take && rx_st == `RX_LRC)
				&& !(chunk_due && rx_st == `RX_NAD); // shut before a chunk starts
			// discard response bytes left over after an abort
			if (flushing && q_valid)
				flush_cnt <= flush_cnt - 1'b1;
			// application hands over a response
			if (rsp_go && rsp_wait && (rsp_len != {LEN_W{1'b0}}))
			begin
				rsp_wait <= 1'b0;
				remain <= rsp_len;
				chunk_due <= 1'b1;
			end
			case (rx_st)
				`RX_NAD:
				begin
					if (rx_take)
					begin
						rx_nad <= rx_data;
						rx_lrc <= rx_data;
						rx_st <= `RX_PCB;
					end
					else if (chunk_due && tx_st == `TX_IDLE && !start_tx)
					begin
						// next i-block of the response, chained if too long
						chunk_due <= 1'b0;
						start_tx <= 1'b1;
						t_src <= `SRC_FIFO;
						ns <= !ns;
						if (remain > ifsd_wide)
						begin
							t_len <= ifsd;
							t_pcb <= ({7'h00, ns} << `PCB_I_SEQ_BIT)
								| (8'h01 << `PCB_I_MORE_BIT);
							remain <= remain - ifsd_wide;
							rsp_chaining <= 1'b1;
						end
						else
						begin
							t_len <= remain[7:0];
							t_pcb <= {7'h00, ns} << `PCB_I_SEQ_BIT;
							remain <= {LEN_W{1'b0}};
							rsp_chaining <= 1'b0;
						end
					end
				end
				`RX_PCB:
				begin
					if (rx_take)
					begin
						rx_pcb <= rx_data;
						rx_lrc <= rx_lrc ^ rx_data;
						rx_st <= `RX_LEN;
					end
				end
				`RX_LEN:
				begin
					if (rx_take)
					begin
						rx_len <= rx_data;
						rx_cnt <= 8'h00;
						rx_lrc <= rx_lrc ^ rx_data;
						rx_st <= (rx_data == 8'h00) ? `RX_LRC : `RX_INF;
					end
				end
				`RX_INF:
				begin
					if (rx_take)
					begin
						if (rx_cnt == 8'h00)
							rx_inf0 <= rx_data;
						rx_cnt <= rx_cnt + 1'b1;
						rx_lrc <= rx_lrc ^ rx_data;
						// stream command bytes of an i-block for this node
						if (is_i && rx_nad == `NAD_ZERO)
						begin
							cmd_data <= rx_data;
							cmd_valid <= 1'b1;
						end
						if (rx_cnt + 1'b1 == rx_len)
							rx_st <= `RX_LRC;
					end
				end
				`RX_LRC:
				begin
					if (rx_take)
					begin
						edc_ok <= ((rx_lrc ^ rx_data) == 8'h00);
						rx_st <= `RX_DO;
					end
				end
				default:
				begin
					if (tx_st == `TX_IDLE && !start_tx)
					begin
						rx_st <= `RX_NAD;
						if (rx_nad != `NAD_ZERO)
						begin
							// foreign address: silent, streamed bytes dropped
							if (is_i && rx_len != 8'h00)
								cmd_drop <= 1'b1;
						end
						else if (!edc_ok)
						begin
							if (is_i && rx_len != 8'h00)
								cmd_drop <= 1'b1;
							send_r(`R_ERR_EDC, nr);
						end
						else if (is_i)
						begin
							if (rx_len == 8'h00 || rx_len > `INF_MAX)
							begin
								if (rx_len != 8'h00)
									cmd_drop <= 1'b1;
								send_r(`R_ERR_OTHER, nr);
							end
							else
							begin
								nr <= !nr;
								cmd_done <= 1'b1;
								if (rx_pcb[`PCB_I_MORE_BIT])
									send_r(`R_ERR_NONE, !nr);
								else
									rsp_wait <= 1'b1;
							end
						end
						else if (is_r)
						begin
							if (rx_len != 8'h00)
								send_r(`R_ERR_OTHER, nr);
							else if (rsp_chaining && rx_pcb[`PCB_R_SEQ_BIT] == ns)
								chunk_due <= 1'b1;
						end
						else if (is_s_req)
						begin
							case (s_type)
								`S_IFS:
								begin
									if (rx_len != `LEN_ONE)
										send_r(`R_ERR_OTHER, nr);
									else if (rx_inf0 > `IFSD_MAX || rx_inf0 == 8'h00)
										send_r(`R_ERR_OTHER, nr);
									else
									begin
										ifsd <= rx_inf0;
										send_s(`S_IFS, `LEN_ONE, rx_inf0);
									end
								end
								`S_RESYNCH:
								begin
									if (rx_len != 8'h00)
										send_r(`R_ERR_OTHER, nr);
									else
									begin
										ns <= 1'b0;
										nr <= 1'b0;
										send_s(`S_RESYNCH, 8'h00, 8'h00);
									end
								end
								`S_ABORT:
								begin
									if (rx_len != 8'h00)
										send_r(`R_ERR_OTHER, nr);
									else
									begin
										// drop the rest of the chained response
										if (rsp_chaining)
										begin
											flush_cnt <= remain;
											remain <= {LEN_W{1'b0}};
											rsp_chaining <= 1'b0;
											rsp_aborted <= 1'b1;
										end
										send_s(`S_ABORT, 8'h00, 8'h00);
									end
								end
								default:
								begin
									// card never asks for more time, a one-byte request gets no answer
									if (rx_len != `LEN_ONE)
										send_r(`R_ERR_OTHER, nr);
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// transmit builder
	// ----------------------------------------
	// address, control, length, information, then check byte
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_st <= `TX_IDLE;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			t_cnt <= 8'h00;
			t_lrc <= 8'h00;
		end
		else
		begin
			if (tx_take)
				t_lrc <= lrc_fold;
			case (tx_st)
				`TX_IDLE:
				begin
					if (start_tx)
					begin
						tx_data <= `NAD_ZERO;
						tx_valid <= 1'b1;
						t_lrc <= 8'h00;
						t_cnt <= 8'h00;
						tx_st <= `TX_NAD;
					end
				end
				`TX_NAD:
				begin
					if (tx_take)
					begin
						tx_data <= t_pcb;
						tx_st <= `TX_PCB;
					end
				end
				`TX_PCB:
				begin
					if (tx_take)
					begin
						tx_data <= t_len;
						tx_st <= `TX_LEN;
					end
				end
				`TX_LEN:
				begin
					if (tx_take)
					begin
						if (t_len == 8'h00)
						begin
							tx_data <= lrc_fold;
							tx_st <= `TX_LRC;
						end
						else
						begin
							tx_valid <= 1'b0;
							tx_st <= `TX_INF;
						end
					end
				end
				`TX_INF:
				begin
					if (tx_slot)
					begin
						if (t_cnt == t_len)
						begin
							tx_data <= lrc_fold;
							tx_valid <= 1'b1;
							tx_st <= `TX_LRC;
						end
						else if (t_src == `SRC_ONE)
						begin
							tx_data <= t_inf;
							tx_valid <= 1'b1;
							t_cnt <= t_cnt + 1'b1;
						end
						else if (q_valid)
						begin
							tx_data <= q_data;
							tx_valid <= 1'b1;
							t_cnt <= t_cnt + 1'b1;
						end
						else
							tx_valid <= 1'b0;
					end
				end
				default:
				begin
					if (tx_take)
					begin
						tx_valid <= 1'b0;
						tx_st <= `TX_IDLE;
					end
				end
			endcase
		end
	end

endmodule // t1_block_framer

// ### tb/t1_block_framer_assertions.sv
// checker for the block framer: card blocks on tx, size, handshakes
// assumes bind onto t1_block_framer, one clock, async low reset
`timescale 1ns/1ns
module t1_block_framer_chk (
	input wire clk,
	input wire rst_b,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_ready,
	input wire cmd_done,
	input wire cmd_drop,
	input wire rsp_aborted,
	input wire [7:0] ifsd
);
	// ----
	// block tracking
	// ----
	reg [8:0] idx;
	reg [7:0] pcb;
	reg [7:0] len;
	reg [7:0] acc;
	wire take = tx_valid && tx_ready;
	wire last = take && idx > 9'h002 && idx == {1'b0, len} + 9'h003;
	wire at_len = take && idx == 9'h002;
	// position, control byte, length and running xor of the card block
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			idx <= 9'h000;
			pcb <= 8'h00;
			len <= 8'h00;
			acc <= 8'h00;
		end
		else if (take)
		begin
			idx <= last ? 9'h000 : idx + 9'h001;
			acc <= last ? 8'h00 : acc ^ tx_data;
			if (idx == 9'h001) pcb <= tx_data;
			if (idx == 9'h002) len <= tx_data;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_reset_size: assert property ($rose(rst_b) |-> ifsd == 8'h20)
		else $error("ifsd wrong after reset");
	chk_addr_zero: assert property (take && idx == 9'h000 |-> tx_data == 8'h00)
		else $error("nonzero address byte");
	chk_lrc_byte: assert property (last |-> tx_data == acc)
		else $error("bad check byte");
	chk_r_empty: assert property (at_len && pcb[7:6] == 2'b10 |-> tx_data == 8'h00)
		else $error("r-block with info");
	chk_s_one: assert property (at_len && pcb == 8'hE1 |-> tx_data == 8'h01)
		else $error("size response length");
	chk_s_empty: assert property (at_len && pcb[7:5] == 3'b111 && !pcb[0] |-> tx_data == 8'h00)
		else $error("empty s-block has info");
	chk_i_len: assert property (at_len && !pcb[7] |-> tx_data != 8'h00 && tx_data <= ifsd)
		else $error("i-block length");
	chk_i_more: assert property (at_len && !pcb[7] && pcb[5] |-> tx_data == ifsd)
		else $error("chained block not full");
	chk_half_duplex: assert property (tx_valid |-> !rx_ready)
		else $error("receive open while sending");
	chk_done_drop: assert property (cmd_drop |-> !cmd_done)
		else $error("done and drop together");
	chk_ifsd_range: assert property (ifsd != 8'h00 && ifsd <= 8'hFE)
		else $error("ifsd out of range");
	cover property (last && pcb == 8'hE1);
	cover property (last && pcb[7:5] == 3'b001);
	cover property (rsp_aborted);
	cover property (cmd_drop);
endmodule // t1_block_framer_chk
bind t1_block_framer t1_block_framer_chk i_chk (.clk(clk), .rst_b(rst_b), .rx_ready(rx_ready),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd_done(cmd_done),
	.cmd_drop(cmd_drop), .rsp_aborted(rsp_aborted), .ifsd(ifsd));

// ### tb/t1_term_model.sv
// terminal model: sends bytes to the card, collects card bytes
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/1ns
module t1_term_model (
	input wire clk,
	input wire rst_b,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output logic tx_ready
);
	logic slow = 1'b0;
	logic [7:0] got[$];
	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// ready every cycle, or every other cycle when slow
	always @(posedge clk)
		tx_ready <= #1 slow ? ~tx_ready : 1'b1;
	// collect taken card bytes
	always @(posedge clk)
		if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
	// offer one byte, held until taken
	task put(input logic [7:0] b);
	begin
		rx_data = b;
		rx_valid = 1'b1;
		@(posedge clk);
		while (rx_ready !== 1'b1) @(posedge clk);
		#1;
	end
	endtask
	// release the line, data no longer shows the last byte
	task idle();
	begin
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	end
	endtask
endmodule // t1_term_model

// ### tb/test_t1_block_framer.sv
// bench for the block framer: terminal blocks in, card blocks checked
// assumes the terminal model on rx/tx and the checker bound to i_dut
`timescale 1ns/1ns
module test_t1_block_framer;
	logic clk;
	logic rst_b;
	logic [7:0] rsp_data;
	logic rsp_valid;
	logic [15:0] rsp_len;
	logic rsp_go;
	wire [7:0] rx_data, tx_data, cmd_data, ifsd;
	wire rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, cmd_done, cmd_drop;
	wire rsp_ready, rsp_wait, rsp_chaining, rsp_aborted;
	int n_fail, checks, n_done, n_drop, n_ab;
	logic [7:0] cmd_q[$];
	logic [7:0] adr[3] = '{8'h01, 8'h10, 8'h11};
	t1_block_framer i_dut (.clk(clk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_done(cmd_done), .cmd_drop(cmd_drop),
		.rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_len(rsp_len),
		.rsp_go(rsp_go), .rsp_wait(rsp_wait), .rsp_chaining(rsp_chaining),
		.rsp_aborted(rsp_aborted), .ifsd(ifsd));
	t1_term_model i_term (.clk(clk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// collect command bytes and event pulses
	always @(posedge clk)
	begin
		if (cmd_valid === 1'b1) cmd_q.push_back(cmd_data);
		if (cmd_done === 1'b1) n_done++;
		if (cmd_drop === 1'b1) n_drop++;
		if (rsp_aborted === 1'b1) n_ab++;
	end
	// ----
	// tasks
	// ----
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
	begin
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	end
	endtask
	// send a block, check byte spoilt by bad
	task blk(input logic [7:0] q[$], input logic [7:0] bad);
		logic [7:0] s;
	begin
		s = bad;
		foreach (q[i])
		begin
			s = s ^ q[i];
			i_term.put(q[i]);
		end
		i_term.put(s);
		i_term.idle();
	end
	endtask
	// await the card block q plus its check byte, nothing more
	task exp_tx(input logic [7:0] q[$]);
		logic [7:0] s;
	begin
		s = 8'h00;
		foreach (q[i]) s = s ^ q[i];
		q.push_back(s);
		for (int k = 0; k < 400 && i_term.got.size() < q.size(); k++) @(posedge clk);
		repeat (4) @(posedge clk);
		#1;
		chk(8'(i_term.got.size()), 8'(q.size()), "tx count");
		foreach (q[i]) if (i < i_term.got.size()) chk(i_term.got[i], q[i], "tx byte");
		i_term.got.delete();
	end
	endtask
	task push(input logic [7:0] b);
	begin
		rsp_data = b;
		rsp_valid = 1'b1;
		@(posedge clk);
		while (rsp_ready !== 1'b1) @(posedge clk);
		#1;
	end
	endtask
	task go(input logic [15:0] n);
	begin
		for (int k = 0; k < 400 && rsp_wait !== 1'b1; k++) @(posedge clk);
		#1;
		chk(rsp_wait, 8'h01, "rsp wait");
		rsp_len = n;
		rsp_go = 1'b1;
		@(posedge clk);
		#1;
		rsp_go = 1'b0;
	end
	endtask
	task wrap_up();
	begin
		$display("checks %0d fails %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#100000;
		n_fail++;
		wrap_up();
	end
	// ----
	// tests
	// ----
	initial
	begin
		rst_b = 1'b0;
		rsp_data = 8'h00;
		rsp_valid = 1'b0;
		rsp_len = 16'h0000;
		rsp_go = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk(ifsd, 8'h20, "ifsd reset");
		repeat (2) @(posedge clk);
		#1;
		blk('{8'h00, 8'h00, 8'h02, 8'hAA, 8'hBB}, 8'h00);
		for (int i = 0; i < 3; i++) push(8'(8'h31 + i));
		rsp_valid = 1'b0;
		go(16'h0003);
		exp_tx('{8'h00, 8'h00, 8'h03, 8'h31, 8'h32, 8'h33});
		chk(8'(cmd_q.size()), 8'h02, "cmd count");
		chk(cmd_q[1], 8'hBB, "cmd byte");
		$display("end command");
		blk('{8'h00, 8'h40, 8'h01, 8'hCC}, 8'h5A);
		exp_tx('{8'h00, 8'h91, 8'h00});
		chk(8'(n_done), 8'h01, "done count");
		$display("end bad check");
		blk('{8'h00, 8'hC1, 8'h01, 8'hFF}, 8'h00);
		exp_tx('{8'h00, 8'h92, 8'h00});
		chk(ifsd, 8'h20, "ifsd kept");
		blk('{8'h00, 8'hC1, 8'h01, 8'hFE}, 8'h00);
		exp_tx('{8'h00, 8'hE1, 8'h01, 8'hFE});
		chk(ifsd, 8'hFE, "ifsd set");
		$display("end size");
		blk('{8'h00, 8'hC0, 8'h00}, 8'h00);
		exp_tx('{8'h00, 8'hE0, 8'h00});
		$display("end resync");
		n_drop = 0;
		foreach (adr[i])
		begin
			blk('{adr[i], 8'h00, 8'h01, 8'h55}, 8'h00);
			repeat (30) @(posedge clk);
			#1;
		end
		chk(8'(i_term.got.size()), 8'h00, "silent");
		chk(8'(n_drop), 8'h03, "drop count");
		$display("end address");
		blk('{8'h00, 8'hC1, 8'h01, 8'h02}, 8'h00);
		exp_tx('{8'h00, 8'hE1, 8'h01, 8'h02});
		blk('{8'h00, 8'h20, 8'h01, 8'h10}, 8'h00);
		exp_tx('{8'h00, 8'h90, 8'h00});
		blk('{8'h00, 8'h40, 8'h01, 8'h11}, 8'h00);
		i_term.slow = 1'b1;
		for (int i = 0; i < 16; i++) push(8'(8'h80 + i));
		rsp_valid = 1'b0;
		chk(rsp_ready, 8'h00, "fifo full");
		go(16'h0010);
		exp_tx('{8'h00, 8'h20, 8'h02, 8'h80, 8'h81});
		chk(rsp_chaining, 8'h01, "chaining");
		blk('{8'h00, 8'h90, 8'h00}, 8'h00);
		exp_tx('{8'h00, 8'h60, 8'h02, 8'h82, 8'h83});
		blk('{8'h00, 8'hC2, 8'h00}, 8'h00);
		exp_tx('{8'h00, 8'hE2, 8'h00});
		chk(8'(n_ab), 8'h01, "aborted");
		$display("end chain abort");
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk(ifsd, 8'h20, "ifsd after reset");
		$display("end reset");
		wrap_up();
	end
endmodule // test_t1_block_framer
